//--- hdl/sebi_fifo.sv
/*
 * small synchronous fifo with valid/ready on both sides.
 * assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/100ps
module sebi_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 4
) (
    input  wire logic         i_clk,
    input  wire logic         i_reset,
    input  wire logic         i_in_valid,
    output logic              o_in_ready,
    input  wire logic [W-1:0] i_in_data,
    output logic              o_out_valid,
    input  wire logic         i_out_ready,
    output logic [W-1:0]      o_out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] wr_d;
    logic [AW-1:0] rd_q;
    logic [AW-1:0] rd_d;
    logic [AW:0]   cnt_q;
    logic [AW:0]   cnt_d;
    logic          push;
    logic          pop;

    assign o_in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign o_out_valid = (cnt_q != '0);
    assign o_out_data  = mem_q[rd_q];

    always_comb
    begin
        push  = i_in_valid & o_in_ready;
        pop   = o_out_valid & i_out_ready;
        wr_d  = push ? ((wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1) : wr_q;
        rd_d  = pop ? ((rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1) : rd_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge i_clk)
    begin
        if (push)
        begin
            mem_q[wr_q] <= i_in_data;
        end
        if (i_reset)
        begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end
endmodule

//--- hdl/sebi_pkg.sv
/*
 * shared constants and types of the serial memory bus interface.
 * assumes a 200 MHz system clock; the serial clock comes from the bus host.
 */
package sebi_pkg;
    localparam int MEM_BYTES     = 32768;
    localparam int ADDR_W        = 15;
    localparam int PAGE_BYTES    = 64;
    localparam int PAGE_W        = 6;
    localparam int PAGES         = 512;
    localparam int BYTE_W        = 8;
    localparam int FIFO_DEPTH    = 4;
    // arbitrary family code sent ahead of the strap bits
    localparam logic [3:0] SEL_FAMILY = 4'ha;
    localparam int CLK_PERIOD_NS = 5;
    localparam int T_PROG_MAX_MS = 5;
    // longest time, rounded down to whole cycles
    localparam int PROG_CYC      = T_PROG_MAX_MS * 1000000 / CLK_PERIOD_NS;
    // bit counter: last data bit sampled at 7, acknowledge slot at 8
    localparam logic [3:0] CNT_LAST_BIT  = 4'h7;
    localparam logic [3:0] CNT_ACK       = 4'h8;
    localparam logic [3:0] CNT_AFTER_SYN = 4'h2;
    localparam logic [ADDR_W-1:0] PTR_RST = 15'h0000;

    typedef enum logic [2:0] {EV_ADDR_HI, EV_ADDR_LO, EV_WDATA, EV_RNEXT, EV_STOP} sebi_ev_t;

    typedef struct packed {
        sebi_ev_t          kind;
        logic [BYTE_W-1:0] data;
    } sebi_evt_t;

    typedef enum {L_IDLE, L_DEV, L_WHI, L_WLO, L_WDAT, L_RDAT} sebi_lst_t;
    typedef enum {P_IDLE, P_PROG} sebi_pst_t;
endpackage

//--- hdl/sebi_top.sv
/*
 * target side of a two-wire serial 32k x 8 nonvolatile memory.
 * assumes the host drives i_scl as a clock and that the pin pad
 * resolves the open-drain data wire and holds the strap/protect pull-downs.
 */
// Summary of operation
// - incoming data bits are sampled on the rising serial clock edge.
// - bits the memory drives change on the falling serial clock edge; a stop or reset releases the line at once.
// - the data line is only pulled low or released, never driven high.
// - the memory answers only when the sent select bits equal its three straps.
// - three strap inputs give eight distinct codes for eight parts on one bus.
// - an open strap input reads low through an internal pull-down.
// - with write protect low, writes are accepted and performed.
// - with write protect high, no write changes the array.
// - an open write protect input reads low, leaving writes enabled.
// - the array holds 32768 bytes of 8 bits.
// - the array is 512 pages of 64 bytes; a multi-byte write stays in one page.
// - a random access carries a 15-bit byte address selecting one byte.
// - page writes of 1 to 64 bytes are accepted.
// - an accepted write programs itself without the serial clock within 5 ms.
`timescale 1ns/100ps
module sebi_top #(
    parameter int PROG_CYC = sebi_pkg::PROG_CYC
) (
    input  wire logic i_clk,
    input  wire logic i_reset,
    input  wire logic i_scl,
    input  wire logic i_sda,
    output logic      o_sda_o,
    output logic      o_sda_oe,
    input  wire logic i_select_strap_bit2,
    input  wire logic i_select_strap_bit1,
    input  wire logic i_select_strap_bit0,
    input  wire logic i_write_protect,
    output logic      o_busy
);
    localparam int TW = $clog2(PROG_CYC + 1);
    localparam int EW = $bits(sebi_pkg::sebi_evt_t);

    // link side, serial clock domain
    logic [7:0]          sh_q, sh_d;
    logic [3:0]          cnt_q, cnt_d;
    sebi_pkg::sebi_lst_t st_q, st_d;
    logic                ack_q, ack_d;
    logic [7:0]          tx_q, tx_d;
    logic                ev_tgl_q, ev_tgl_d;
    sebi_pkg::sebi_evt_t ev_q, ev_d;
    logic                syn_seen_q;
    logic                syn_p2_q;
    logic                syn_n1_q;
    logic                hold1_q, hold2_q;
    logic                rl1_q, rl2_q;
    logic [2:0]          strap1_q, strap2_q;
    logic                oe_q, oe_d;

    // system side
    logic                scl1_q, scl2_q, sda1_q, sda2_q, sda3_q;
    logic                wp1_q, wp2_q;
    logic                evt1_q, evt2_q, evt3_q;
    logic                syn_tgl_q, syn_tgl_d;
    logic                quiet_q, quiet_d;
    logic                lpend_q, lpend_d;
    logic                spend_q, spend_d;
    logic                busy_q, busy_d;
    sebi_pkg::sebi_pst_t pst_q, pst_d;
    logic [sebi_pkg::ADDR_W-1:0] ptr_q, ptr_d;
    logic [sebi_pkg::PAGE_BYTES-1:0] pval_q, pval_d;
    logic                pend_q, pend_d;
    logic [TW-1:0]       tmr_q, tmr_d;
    logic [sebi_pkg::PAGE_W:0] idx_q, idx_d;
    logic [7:0]          rd_q;
    logic [7:0]          mem_q [sebi_pkg::MEM_BYTES];
    logic [7:0]          pbuf_q [sebi_pkg::PAGE_BYTES];
    logic                mem_we, pbuf_we;
    logic [sebi_pkg::ADDR_W-1:0] mem_wa;
    logic [sebi_pkg::PAGE_W-1:0] pbuf_wa;
    logic [7:0]          mem_wd, pbuf_wd;
    logic                f_in_valid, f_in_ready, f_out_valid, f_out_ready;
    sebi_pkg::sebi_evt_t f_in_data, f_out_data;
    logic                start_det, stop_det;

    function automatic sebi_pkg::sebi_evt_t mk_ev(input sebi_pkg::sebi_ev_t k, input logic [7:0] d);
        sebi_pkg::sebi_evt_t e;
        e.kind = k;
        e.data = d;
        return e;
    endfunction

    // link, rising edge: sample and decide
    always_comb
    begin
        sh_d       = {sh_q[6:0], i_sda};
        cnt_d      = cnt_q;
        st_d       = st_q;
        ack_d      = ack_q;
        tx_d       = tx_q;
        ev_tgl_d   = ev_tgl_q;
        ev_d       = ev_q;
        if (rl2_q)
        begin
            st_d     = sebi_pkg::L_IDLE;
            ack_d    = 1'b0;
            cnt_d    = 4'h0;
            // toggle must start equal to its system-side copy
            ev_tgl_d = 1'b0;
        end
        else if (syn_p2_q != syn_seen_q)
        begin
            // start seen one edge late: two address bits already shifted in
            st_d  = sebi_pkg::L_DEV;
            cnt_d = sebi_pkg::CNT_AFTER_SYN;
            ack_d = 1'b0;
        end
        else if (st_q != sebi_pkg::L_IDLE)
        begin
            if (cnt_q < sebi_pkg::CNT_LAST_BIT)
            begin
                cnt_d = cnt_q + 4'h1;
            end
            else if (cnt_q == sebi_pkg::CNT_LAST_BIT)
            begin
                cnt_d = sebi_pkg::CNT_ACK;
                ack_d = ~hold2_q;
                case (st_q)
                    sebi_pkg::L_DEV:
                    begin
                        ack_d = ~hold2_q & (sh_d[7:1] == {sebi_pkg::SEL_FAMILY, strap2_q});
                    end
                    sebi_pkg::L_WHI:
                    begin
                        ev_d = mk_ev(sebi_pkg::EV_ADDR_HI, sh_d);
                    end
                    sebi_pkg::L_WLO:
                    begin
                        ev_d = mk_ev(sebi_pkg::EV_ADDR_LO, sh_d);
                    end
                    sebi_pkg::L_WDAT:
                    begin
                        ev_d = mk_ev(sebi_pkg::EV_WDATA, sh_d);
                    end
                    sebi_pkg::L_RDAT:
                    begin
                        ack_d = 1'b0;
                        ev_d  = mk_ev(sebi_pkg::EV_RNEXT, 8'h00);
                    end
                    default:
                    begin
                        ack_d = 1'b0;
                    end
                endcase
                if ((st_q != sebi_pkg::L_DEV) && (st_q != sebi_pkg::L_IDLE) && (ack_d || st_q == sebi_pkg::L_RDAT))
                begin
                    ev_tgl_d = ~ev_tgl_q;
                end
            end
            else
            begin
                cnt_d = 4'h0;
                ack_d = 1'b0;
                tx_d  = rd_q;  // stable: last event handled many cycles ago
                case (st_q)
                    sebi_pkg::L_DEV:
                    begin
                        st_d = !ack_q ? sebi_pkg::L_IDLE : (sh_q[0] ? sebi_pkg::L_RDAT : sebi_pkg::L_WHI);
                    end
                    sebi_pkg::L_WHI:
                    begin
                        st_d = ack_q ? sebi_pkg::L_WLO : sebi_pkg::L_IDLE;
                    end
                    sebi_pkg::L_WLO:
                    begin
                        st_d = ack_q ? sebi_pkg::L_WDAT : sebi_pkg::L_IDLE;
                    end
                    sebi_pkg::L_WDAT:
                    begin
                        st_d = ack_q ? sebi_pkg::L_WDAT : sebi_pkg::L_IDLE;
                    end
                    sebi_pkg::L_RDAT:
                    begin
                        st_d = i_sda ? sebi_pkg::L_IDLE : sebi_pkg::L_RDAT;
                    end
                    default:
                    begin
                        st_d = sebi_pkg::L_IDLE;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge i_scl)
    begin
        sh_q       <= sh_d;
        cnt_q      <= cnt_d;
        st_q       <= st_d;
        ack_q      <= ack_d;
        tx_q       <= tx_d;
        ev_tgl_q   <= ev_tgl_d;
        ev_q       <= ev_d;
        syn_p2_q   <= syn_n1_q;
        syn_seen_q <= syn_p2_q;
        hold1_q    <= busy_q;
        hold2_q    <= hold1_q;
        rl1_q      <= i_reset;
        rl2_q      <= rl1_q;
        // pad pull-downs make open straps read low
        strap1_q   <= {i_select_strap_bit2, i_select_strap_bit1, i_select_strap_bit0};
        strap2_q   <= strap1_q;
    end

    // link, falling edge: drive
    always_comb
    begin
        oe_d = 1'b0;
        if (st_q != sebi_pkg::L_IDLE)
        begin
            if (cnt_q == sebi_pkg::CNT_ACK)
            begin
                oe_d = ack_q;
            end
            else if (st_q == sebi_pkg::L_RDAT)
            begin
                oe_d = ~tx_q[~cnt_q[2:0]];
            end
        end
    end

    // half-cycle synchroniser: falling then rising edge, start is ~0.5 us ahead
    always_ff @(negedge i_scl)
    begin
        syn_n1_q <= syn_tgl_q;
        oe_q     <= oe_d;
    end

    assign o_sda_o  = 1'b0;
    assign o_sda_oe = oe_q & ~quiet_q;
    assign o_busy   = busy_q;

    // system side: start/stop detection and event intake
    always_comb
    begin
        start_det  = scl2_q & sda3_q & ~sda2_q;
        stop_det   = scl2_q & ~sda3_q & sda2_q;
        syn_tgl_d  = syn_tgl_q ^ start_det;
        quiet_d    = stop_det ? 1'b1 : (start_det ? 1'b0 : quiet_q);
        lpend_d    = lpend_q | (evt2_q ^ evt3_q);
        spend_d    = spend_q | stop_det;
        f_in_valid = lpend_q | spend_q;
        f_in_data  = lpend_q ? ev_q : mk_ev(sebi_pkg::EV_STOP, 8'h00);
        if (f_in_ready & lpend_q)
        begin
            lpend_d = evt2_q ^ evt3_q;
        end
        else if (f_in_ready & spend_q)
        begin
            spend_d = stop_det;
        end
    end

    sebi_fifo #(
        .W     (EW),
        .DEPTH (sebi_pkg::FIFO_DEPTH)
    ) u_fifo (
        .i_clk       (i_clk),
        .i_reset     (i_reset),
        .i_in_valid  (f_in_valid),
        .o_in_ready  (f_in_ready),
        .i_in_data   (f_in_data),
        .o_out_valid (f_out_valid),
        .i_out_ready (f_out_ready),
        .o_out_data  (f_out_data)
    );

    // event handling and self-timed programming
    always_comb
    begin
        f_out_ready = (pst_q == sebi_pkg::P_IDLE);
        ptr_d   = ptr_q;
        pval_d  = pval_q;
        pend_d  = pend_q;
        pst_d   = pst_q;
        tmr_d   = tmr_q;
        idx_d   = idx_q;
        mem_we  = 1'b0;
        mem_wa  = {ptr_q[sebi_pkg::ADDR_W-1:sebi_pkg::PAGE_W], idx_q[sebi_pkg::PAGE_W-1:0]};
        mem_wd  = pbuf_q[idx_q[sebi_pkg::PAGE_W-1:0]];
        pbuf_we = 1'b0;
        pbuf_wa = ptr_q[sebi_pkg::PAGE_W-1:0];
        pbuf_wd = f_out_data.data;
        if (pst_q == sebi_pkg::P_IDLE)
        begin
            if (f_out_valid)
            begin
                case (f_out_data.kind)
                    sebi_pkg::EV_ADDR_HI:
                    begin
                        ptr_d[14:8] = f_out_data.data[6:0];
                        pval_d      = '0;
                        pend_d      = 1'b0;
                    end
                    sebi_pkg::EV_ADDR_LO:
                    begin
                        ptr_d[7:0] = f_out_data.data;
                    end
                    sebi_pkg::EV_WDATA:
                    begin
                        if (!wp2_q)
                        begin
                            pbuf_we         = 1'b1;
                            pval_d[pbuf_wa] = 1'b1;
                            pend_d          = 1'b1;
                        end
                        ptr_d[sebi_pkg::PAGE_W-1:0] = ptr_q[sebi_pkg::PAGE_W-1:0] + 6'h01;
                    end
                    sebi_pkg::EV_RNEXT:
                    begin
                        ptr_d = ptr_q + 15'h0001;
                    end
                    sebi_pkg::EV_STOP:
                    begin
                        // protect pad pull-down keeps an open pin low
                        if (pend_q && !wp2_q)
                        begin
                            pst_d = sebi_pkg::P_PROG;
                            tmr_d = TW'(PROG_CYC - 1);
                            idx_d = '0;
                        end
                        pend_d = 1'b0;
                    end
                    default:
                    begin
                        pend_d = pend_q;
                    end
                endcase
            end
        end
        else
        begin
            // one byte per cycle: the page is written long before the timer ends
            if (!idx_q[sebi_pkg::PAGE_W])
            begin
                mem_we = pval_q[idx_q[sebi_pkg::PAGE_W-1:0]];
                idx_d  = idx_q + 7'h01;
            end
            if (tmr_q == '0)
            begin
                pst_d  = sebi_pkg::P_IDLE;
                pval_d = '0;
            end
            else
            begin
                tmr_d = tmr_q - TW'(1);
            end
        end
        busy_d = (pst_d == sebi_pkg::P_PROG);
    end

    always_ff @(posedge i_clk)
    begin
        scl1_q <= i_scl;
        scl2_q <= scl1_q;
        sda1_q <= i_sda;
        sda2_q <= sda1_q;
        sda3_q <= sda2_q;
        wp1_q  <= i_write_protect;
        wp2_q  <= wp1_q;
        evt1_q <= ev_tgl_q;
        evt2_q <= evt1_q;
        evt3_q <= evt2_q;
        rd_q   <= mem_q[ptr_q];
        if (mem_we)
        begin
            mem_q[mem_wa] <= mem_wd;
        end
        if (pbuf_we)
        begin
            pbuf_q[pbuf_wa] <= pbuf_wd;
        end
        if (i_reset)
        begin
            syn_tgl_q <= 1'b0;
            quiet_q   <= 1'b1;
            lpend_q   <= 1'b0;
            spend_q   <= 1'b0;
            busy_q    <= 1'b0;
            pst_q     <= sebi_pkg::P_IDLE;
            ptr_q     <= sebi_pkg::PTR_RST;
            pval_q    <= '0;
            pend_q    <= 1'b0;
            tmr_q     <= '0;
            idx_q     <= '0;
        end
        else
        begin
            syn_tgl_q <= syn_tgl_d;
            quiet_q   <= quiet_d;
            lpend_q   <= lpend_d;
            spend_q   <= spend_d;
            busy_q    <= busy_d;
            pst_q     <= pst_d;
            ptr_q     <= ptr_d;
            pval_q    <= pval_d;
            pend_q    <= pend_d;
            tmr_q     <= tmr_d;
            idx_q     <= idx_d;
        end
    end
endmodule

//--- verif/sebi_chk_sva.sv
/*
 * port-level checker for the serial memory target.
 * assumes the bench resolves the data wire and holds straps and protect steady around frames.
 */
`timescale 1ns/100ps
module sebi_chk #(
    parameter int PROG_CYC = 4000
) (
    input  wire logic i_clk,
    input  wire logic i_reset,
    input  wire logic i_scl,
    input  wire logic i_sda,
    input  wire logic o_sda_o,
    input  wire logic o_sda_oe,
    input  wire logic i_select_strap_bit2,
    input  wire logic i_select_strap_bit1,
    input  wire logic i_select_strap_bit0,
    input  wire logic i_write_protect,
    input  wire logic o_busy
);
    logic        scl_q;
    logic        sda_q;
    logic [31:0] busy_cnt_q;
    logic [31:0] busy_cnt_d;
    logic [3:0]  since_stop_q;
    logic [3:0]  since_stop_d;

    always_comb
    begin
        busy_cnt_d = o_busy ? busy_cnt_q + 32'h1 : 32'h0;
        if (i_scl && scl_q && i_sda && !sda_q)
            since_stop_d = 4'h0;
        else
            since_stop_d = (since_stop_q == 4'hf) ? 4'hf : since_stop_q + 4'h1;
    end

    always_ff @(posedge i_clk)
    begin
        scl_q        <= i_reset ? 1'b1 : i_scl;
        sda_q        <= i_reset ? 1'b1 : i_sda;
        busy_cnt_q   <= i_reset ? 32'h0 : busy_cnt_d;
        since_stop_q <= i_reset ? 4'hf : since_stop_d;
    end

    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);

    a_drive_low_only: assert property (o_sda_o == 1'b0)
        else $error("data pin value not low");
    a_oe_rise_low: assert property ($rose(o_sda_oe) |-> !i_scl)
        else $error("data pull began while serial clock high");
    a_oe_steady_high: assert property (i_scl && $past(i_scl) && since_stop_q > 4'h6 |-> $stable(o_sda_oe))
        else $error("data pull moved while serial clock high");
    a_busy_exact: assert property ($fell(o_busy) |-> busy_cnt_q == 32'(PROG_CYC))
        else $error("programming time wrong");
    a_busy_limit: assert property (o_busy |-> busy_cnt_q < 32'(PROG_CYC))
        else $error("programming too long");
    a_busy_after_stop: assert property ($rose(o_busy) |-> since_stop_q < 4'h8)
        else $error("programming began without stop");
    a_protect_block: assert property ($rose(o_busy) |-> !$past(i_write_protect, 8))
        else $error("programming while protected");
    a_reset_quiet: assert property (disable iff (1'b0) $past(i_reset) |-> !o_sda_oe && !o_busy)
        else $error("outputs active in reset");

    c_prog: cover property ($fell(o_busy));
    c_ack: cover property ($rose(o_sda_oe));
    c_protect: cover property (i_write_protect && since_stop_q == 4'h0);
endmodule

bind sebi_top sebi_chk #(.PROG_CYC(PROG_CYC)) u_chk (.i_clk(i_clk), .i_reset(i_reset), .i_scl(i_scl),
    .i_sda(i_sda), .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe), .i_select_strap_bit2(i_select_strap_bit2),
    .i_select_strap_bit1(i_select_strap_bit1), .i_select_strap_bit0(i_select_strap_bit0),
    .i_write_protect(i_write_protect), .o_busy(o_busy));

//--- verif/sebi_host.sv
/*
 * behavioural two-wire bus host: start, stop and byte transfers.
 * assumes a pull-up on the data wire; the serial clock stands high between frames.
 */
`timescale 1ns/100ps
module sebi_host #(
    parameter int Q = 50
) (
    input  wire logic  i_clk,
    input  wire logic  i_sda,
    output logic       o_scl,
    output logic       o_sda_low,
    output logic [8:0] o_res,
    output logic       o_stb
);
    initial
    begin
        o_scl     = 1'b1;
        o_sda_low = 1'b0;
        o_res     = 9'h000;
        o_stb     = 1'b0;
    end

    // q system cycles is a quarter of a 1 us serial period
    task automatic hw(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    // short burst with the wire released, only so reset reaches the link side
    task automatic pulse(input int n);
        repeat (n)
        begin
            #0.5 o_scl = 1'b0;
            #0.5 o_scl = 1'b1;
        end
    endtask

    task automatic start();
        hw(Q);
        o_sda_low = 1'b0;
        hw(Q);
        o_scl = 1'b1;
        hw(Q);
        o_sda_low = 1'b1;
        hw(2 * Q);
        o_scl = 1'b0;
    endtask

    task automatic stop();
        hw(Q);
        o_sda_low = 1'b1;
        hw(Q);
        o_scl = 1'b1;
        hw(Q);
        o_sda_low = 1'b0;
        hw(2 * Q);
    endtask

    // result: wire level Q cycles after each rise, eight bits then acknowledge
    task automatic xfer(input logic [7:0] b, input logic rd, input logic nack);
        logic [8:0] r;
        logic [8:0] tx;
        tx = {b, nack};
        for (int i = 8; i >= 0; i--)
        begin
            hw(Q);
            o_sda_low = (i == 0) ? (rd && !tx[0]) : (!rd && !tx[i]);
            hw(Q);
            o_scl = 1'b1;
            hw(Q);
            r[i] = i_sda;
            hw(Q);
            o_scl = 1'b0;
        end
        o_res = r;
        o_stb = 1'b1;
        hw(1);
        o_stb = 1'b0;
    endtask
endmodule

//--- verif/tb_top.sv
/*
 * self-checking bench for the serial memory target.
 * assumes the host model owns the serial clock; the wire is resolved here.
 */
`timescale 1ns/100ps
module tb_top;
    localparam int PROG = 6000;
    logic              i_clk;
    logic              i_reset;
    logic              wp;
    logic [2:0]        strap;
    logic              scl;
    logic              host_low;
    logic              sda_o;
    logic              sda_oe;
    logic              busy;
    logic              stb;
    logic [8:0]        res;
    logic [17:0]       exp_q[$];
    logic [7:0]        d0;
    logic [7:0]        d1;
    logic [7:0]        d2;
    logic [14:0]       base;
    int                error_cnt = 0;
    int                comparisons = 0;
    int                seed = 33;
    wire logic         sda_w = (sda_oe === 1'b1 || host_low) ? 1'b0 : 1'b1;

    sebi_top #(.PROG_CYC(PROG)) dut (.i_clk(i_clk), .i_reset(i_reset), .i_scl(scl), .i_sda(sda_w),
        .o_sda_o(sda_o), .o_sda_oe(sda_oe), .i_select_strap_bit2(strap[2]), .i_select_strap_bit1(strap[1]),
        .i_select_strap_bit0(strap[0]), .i_write_protect(wp), .o_busy(busy));
    sebi_host u_host (.i_clk(i_clk), .i_sda(sda_w), .o_scl(scl), .o_sda_low(host_low), .o_res(res), .o_stb(stb));

    initial
    begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        if (error_cnt == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // mask m selects which of the nine sampled bits are judged
    task automatic wb(input logic [7:0] b, input logic [8:0] e, input logic [8:0] m, input logic rd);
        exp_q.push_back({m, e});
        u_host.xfer(b, rd, 1'b1);
    endtask

    function automatic logic [7:0] dev(input logic r);
        return {sebi_pkg::SEL_FAMILY, strap, r};
    endfunction

    task automatic head(input logic [14:0] a);
        u_host.start();
        wb(dev(1'b0), {dev(1'b0), 1'b0}, 9'h1ff, 1'b0);
        wb({1'b0, a[14:8]}, {1'b0, a[14:8], 1'b0}, 9'h1ff, 1'b0);
        wb(a[7:0], {a[7:0], 1'b0}, 9'h1ff, 1'b0);
    endtask

    task automatic write(input logic [14:0] a, input logic [7:0] x, input logic [7:0] y, input int n);
        head(a);
        wb(x, {x, 1'b0}, 9'h1ff, 1'b0);
        if (n > 1)
            wb(y, {y, 1'b0}, 9'h1ff, 1'b0);
        u_host.stop();
    endtask

    task automatic read(input logic [14:0] a, input logic [7:0] x);
        head(a);
        u_host.start();
        wb(dev(1'b1), {dev(1'b1), 1'b0}, 9'h1ff, 1'b0);
        wb(8'hff, {x, 1'b1}, 9'h1ff, 1'b1);
        u_host.stop();
    endtask

    task automatic wait_busy(input logic v, input int lim);
        for (int k = 0; k < lim && busy !== v; k++)
        begin
            @(posedge i_clk);
            #1;
        end
        if (busy !== v)
        begin
            error_cnt++;
            test_done();
        end
    endtask

    initial
    begin
        logic [17:0] e;
        forever
        begin
            @(posedge stb);
            if (exp_q.size() == 0)
                error_cnt++;
            else
            begin
                e = exp_q.pop_front();
                check(res & e[17:9], e[8:0] & e[17:9]);
            end
        end
    end

    initial
    begin
        i_reset = 1'b1;
        wp = 1'b0;
        strap = 3'($random(seed));
        d0 = 8'($random(seed));
        d1 = 8'($random(seed));
        // must differ from the stored byte so a blocked write shows
        d2 = ~d1;
        base = {9'($random(seed)), 6'h00};
        // the link side only sees reset on serial clock edges
        @(posedge i_clk);
        #1;
        u_host.pulse(3);
        repeat (4) @(posedge i_clk);
        #1;
        i_reset = 1'b0;
        u_host.pulse(2);
        repeat (3) @(posedge i_clk);
        #1;
        // every strap code: only the own one is acknowledged
        for (int k = 0; k < 8; k++)
        begin
            u_host.start();
            wb({sebi_pkg::SEL_FAMILY, 3'(k), 1'b0}, {sebi_pkg::SEL_FAMILY, 3'(k), 1'b0, 3'(k) != strap}, 9'h1ff, 1'b0);
            u_host.stop();
        end
        // two bytes from the last page offset: the second wraps to offset zero
        write(base | 15'h003f, d0, d1, 2);
        wait_busy(1'b1, 20);
        // select byte acknowledge left open while programming, address byte must be refused
        u_host.start();
        wb(dev(1'b0), {dev(1'b0), 1'b0}, 9'h1fe, 1'b0);
        wb({1'b0, base[14:8]}, {1'b0, base[14:8], 1'b1}, 9'h1ff, 1'b0);
        u_host.stop();
        wait_busy(1'b0, PROG + 10);
        read(base | 15'h003f, d0);
        read(base, d1);
        wp = 1'b1;
        write(base, d2, d2, 1);
        repeat (20) @(posedge i_clk);
        #1;
        check({8'h00, busy}, 9'h000);
        read(base, d1);
        wp = 1'b0;
        if (exp_q.size() != 0)
            error_cnt++;
        test_done();
    end
endmodule
